// ===== include/input_port_map.svh
`ifndef INPUT_PORT_MAP_SVH
`define INPUT_PORT_MAP_SVH

// bus clock rate, in MHz
`define IPM_CLK_MHZ 40

// input delay figures, in microseconds
`define IPM_DLY_0P1_US 100
`define IPM_DLY_0P5_US 500
`define IPM_DLY_3_US 3000
`define IPM_DLY_15_US 15000

// delay figures as clock cycles (exact at 40 MHz, so rounding is moot)
`define IPM_DLY_0P1_CYC (`IPM_DLY_0P1_US * `IPM_CLK_MHZ)
`define IPM_DLY_0P5_CYC (`IPM_DLY_0P5_US * `IPM_CLK_MHZ)
`define IPM_DLY_3_CYC (`IPM_DLY_3_US * `IPM_CLK_MHZ)
`define IPM_DLY_15_CYC (`IPM_DLY_15_US * `IPM_CLK_MHZ)

// width of a delay counter; must hold the 15 ms count
`define IPM_CNT_W 20

// lines rated for 100 kHz; the others are rated for 1 kHz
`define IPM_FAST_LINES 16'h8EDB

// process image byte indexes; byte address is four times the index
`define IPM_IDX_IMAGE_LOW 136
`define IPM_IDX_IMAGE_HIGH 137
`define IPM_ADDR_IMAGE_LOW (4 * `IPM_IDX_IMAGE_LOW)
`define IPM_ADDR_IMAGE_HIGH (4 * `IPM_IDX_IMAGE_HIGH)

// control and status word addresses
`define IPM_ADDR_RISE_EN 12'h000
`define IPM_ADDR_FALL_EN 12'h004
`define IPM_ADDR_DELAY_SEL 12'h008
`define IPM_ADDR_IRQ_STATUS 12'h00C
`define IPM_ADDR_IRQ_MASK 12'h010

// status and mask layout: one edge bit per line, then the lost-edge bit
`define IPM_STAT_W 17
`define IPM_STAT_LOST_BIT 16

// reset values
`define IPM_RST_RISE_EN 16'h0000
`define IPM_RST_FALL_EN 16'h0000
`define IPM_RST_DELAY_SEL 8'h00
`define IPM_RST_MASK 17'h00000

`endif

// ===== include/input_port_pkg.sv
package input_port_pkg;

    // delay choice of one group of four lines
    typedef enum logic [1:0] {
        DLY_0P1,
        DLY_0P5,
        DLY_3,
        DLY_15
    } delay_code_t;

    // state of one line filter
    typedef struct packed {
        logic sync_a;      // first synchroniser stage
        logic sync_b;      // second synchroniser stage
        logic level;       // accepted (filtered) level
        logic [19:0] cnt;  // cycles the synced level has differed
    } filter_state_t;

    // state of the port
    typedef struct packed {
        logic [15:0] rise_en;   // per-line rising edge enables
        logic [15:0] fall_en;   // per-line falling edge enables
        logic [7:0] delay_sel;  // two bits per group of four lines
        logic [16:0] status;    // sticky edge bits and lost bit
        logic [16:0] mask;      // interrupt enables, same layout
        logic [15:0] prev;      // filtered levels one cycle ago
        logic wr_pend;          // write data phase in progress
        logic [11:0] wr_addr;   // address of that write
        logic [31:0] rdata;     // read data for the data phase
        logic irq;              // interrupt line
    } port_state_t;

endpackage

// ===== logic/line_filter.sv
`timescale 1ns/1ps
`include "input_port_map.svh"

// one input line: synchroniser then a symmetric delay filter
module line_filter #(
    parameter int CNT_W = `IPM_CNT_W
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic enable_in,              // clock enable
    input wire logic raw_in,                 // field pin level, asynchronous
    input wire logic [CNT_W-1:0] limit_in,   // cycles a new level must hold
    output logic level_out                   // filtered level, from a flop
);

    input_port_pkg::filter_state_t st;
    input_port_pkg::filter_state_t next_st;

    // the counter restarts whenever the synced level agrees again, so
    // bounces shorter than the delay never reach the filtered level
    always_comb begin
        next_st = st;
        next_st.sync_a = raw_in;
        next_st.sync_b = st.sync_a;
        if (st.sync_b == st.level) begin
            next_st.cnt = '0;
        end else if (20'(st.cnt) + 20'h00001 >= 20'(limit_in)) begin
            next_st.level = st.sync_b;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + 20'h00001;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else if (enable_in) begin
            st <= next_st;
        end
    end

    assign level_out = st.level;

endmodule

// ===== logic/sixteen_line_input_port.sv
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "input_port_map.svh"

// Overview of operation
// - per-line rise/fall interrupt enables, default off
// - rising is 0-1, falling is 1-0
// - diagnostic event only for lost edge interrupts
// - one delay setting per four-line group
// - delays: 0.1, 0.5, 3, 15 ms
// - slow lines use 0.5 ms instead of 0.1
// - ten lines fast at 100 kHz, six slow
// - lines as bytes at indexes 136, 137
// - counter track, gate and capture routing
// - lines 1,4,7,10 feed frequency channels
// - green indicator lit while line reads high
module sixteen_line_input_port #(
    parameter logic [15:0] FAST_LINES = `IPM_FAST_LINES,
    parameter int CNT_W = `IPM_CNT_W,
    parameter int DLY_0P5_CYC = `IPM_DLY_0P5_CYC,
    parameter int DLY_3_CYC = `IPM_DLY_3_CYC,
    parameter int DLY_15_CYC = `IPM_DLY_15_CYC
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // field side
    input wire logic [15:0] line_in,
    input wire logic input_section_supply_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // interrupt and diagnostics
    output logic irq_out,
    output logic diag_event_out,
    // counter and frequency unit feeds
    output logic [3:0] count_track_a_out,
    output logic [3:0] count_track_b_out,
    output logic count_gate_out,
    output logic count_capture_out,
    output logic [3:0] freq_meas_out,
    // status indicators
    output logic [15:0] line_led_out,
    output logic supply_led_out
);

    // the shortest delay fits well below the parameter threshold
    localparam logic [CNT_W-1:0] CYC_0P1 = CNT_W'(`IPM_DLY_0P1_CYC);
    localparam logic [CNT_W-1:0] CYC_0P5 = CNT_W'(DLY_0P5_CYC);
    localparam logic [CNT_W-1:0] CYC_3 = CNT_W'(DLY_3_CYC);
    localparam logic [CNT_W-1:0] CYC_15 = CNT_W'(DLY_15_CYC);
    localparam logic [11:0] ADDR_LOW = 12'(`IPM_ADDR_IMAGE_LOW);
    localparam logic [11:0] ADDR_HIGH = 12'(`IPM_ADDR_IMAGE_HIGH);

    input_port_pkg::port_state_t st;        // all port state
    input_port_pkg::port_state_t next_st;   // its next value

    logic [CNT_W-1:0] limit [16];   // delay count per line
    logic [15:0] level;             // filtered line levels
    logic [15:0] rise_evt;          // enabled rising edges this cycle
    logic [15:0] fall_evt;          // enabled falling edges this cycle
    logic [15:0] edge_evt;          // either kind
    logic [15:0] lost_evt;          // edges hitting a still-pending bit
    logic [16:0] clr;               // write-one-to-clear bits this cycle
    logic addr_take;                // valid address phase for this slave
    logic [11:0] addr;              // word aligned offset
    logic [31:0] rd_word;           // read mux for the address phase
    logic supply_a;                 // supply sense, first stage
    logic supply_b;                 // supply sense, second stage

    // per-line delay count from the line's group code
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // lines 4g..4g+3 share one code
            unique case (input_port_pkg::delay_code_t'(st.delay_sel[2*(i/4) +: 2]))
                input_port_pkg::DLY_0P1: begin
                    // slow lines cannot follow 0.1 ms, so they get 0.5 ms
                    limit[i] = FAST_LINES[i] ? CYC_0P1 : CYC_0P5;
                end
                input_port_pkg::DLY_0P5: begin
                    limit[i] = CYC_0P5;
                end
                input_port_pkg::DLY_3: begin
                    limit[i] = CYC_3;
                end
                input_port_pkg::DLY_15: begin
                    limit[i] = CYC_15;
                end
            endcase
        end
    end

    // one filter per line
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : gen_line
            line_filter #(
                .CNT_W(CNT_W)
            ) u_filter (
                .clock_in(clock_in),
                .resetn_in(resetn_in),
                .enable_in(enable_in),
                .raw_in(line_in[g]),
                .limit_in(limit[g]),
                .level_out(level[g])
            );
        end
    endgenerate

    // edge events on the filtered level, never the raw pin
    assign rise_evt = level & ~st.prev & st.rise_en;
    assign fall_evt = ~level & st.prev & st.fall_en;
    assign edge_evt = rise_evt | fall_evt;

    // an edge whose line still holds an uncleared pending bit is lost;
    // a clear in the same cycle counts as serviced, so that is no loss
    assign lost_evt = edge_evt & st.status[15:0] & ~clr[15:0];

    // write-one-to-clear strobe from the status write data phase
    always_comb begin
        clr = '0;
        if (st.wr_pend && st.wr_addr == `IPM_ADDR_IRQ_STATUS) begin
            clr = hwdata_in[16:0];
        end
    end

    // address phase decode; only whole words are served
    assign addr_take = hsel_in && htrans_in[1] && hready_in;
    assign addr = {haddr_in[11:2], 2'b00};

    // read mux, registered into the data phase
    always_comb begin
        rd_word = 32'h00000000;
        unique case (addr)
            `IPM_ADDR_RISE_EN: begin
                rd_word = {16'h0000, st.rise_en};
            end
            `IPM_ADDR_FALL_EN: begin
                rd_word = {16'h0000, st.fall_en};
            end
            `IPM_ADDR_DELAY_SEL: begin
                rd_word = {24'h000000, st.delay_sel};
            end
            `IPM_ADDR_IRQ_STATUS: begin
                rd_word = {15'h0000, st.status};
            end
            `IPM_ADDR_IRQ_MASK: begin
                rd_word = {15'h0000, st.mask};
            end
            ADDR_LOW: begin
                // lines 0..7, line 0 in bit 0
                rd_word = {24'h000000, level[7:0]};
            end
            ADDR_HIGH: begin
                // lines 8..15, line 8 in bit 0
                rd_word = {24'h000000, level[15:8]};
            end
            default: begin
                // unmapped words read as zero
                rd_word = 32'h00000000;
            end
        endcase
    end

    // next state of the port
    always_comb begin
        next_st = st;
        next_st.prev = level;

        // write data phase: hwdata stands now
        if (st.wr_pend) begin
            unique case (st.wr_addr)
                `IPM_ADDR_RISE_EN: begin
                    next_st.rise_en = hwdata_in[15:0];
                end
                `IPM_ADDR_FALL_EN: begin
                    next_st.fall_en = hwdata_in[15:0];
                end
                `IPM_ADDR_DELAY_SEL: begin
                    next_st.delay_sel = hwdata_in[7:0];
                end
                `IPM_ADDR_IRQ_MASK: begin
                    next_st.mask = hwdata_in[16:0];
                end
                default: begin
                    // status clears go through clr; others are ignored
                    next_st.mask = st.mask;
                end
            endcase
        end

        // sticky events: a new event beats a clear in the same cycle
        next_st.status[15:0] = (st.status[15:0] & ~clr[15:0]) | edge_evt;
        // the lost bit is the only diagnostic source
        next_st.status[`IPM_STAT_LOST_BIT] =
            (st.status[`IPM_STAT_LOST_BIT] & ~clr[`IPM_STAT_LOST_BIT])
            | (|lost_evt);

        // latch the address phase of a new transfer
        next_st.wr_pend = addr_take && hwrite_in;
        if (addr_take) begin
            next_st.wr_addr = addr;
        end
        if (addr_take && !hwrite_in) begin
            next_st.rdata = rd_word;
        end

        // level interrupt from the next status so it tracks without lag
        next_st.irq = |(next_st.status & st.mask);
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st.rise_en <= `IPM_RST_RISE_EN;
            st.fall_en <= `IPM_RST_FALL_EN;
            st.delay_sel <= `IPM_RST_DELAY_SEL;
            st.status <= '0;
            st.mask <= `IPM_RST_MASK;
            st.prev <= '0;
            st.wr_pend <= 1'b0;
            st.wr_addr <= '0;
            st.rdata <= '0;
            st.irq <= 1'b0;
        end else if (enable_in) begin
            st <= next_st;
        end
    end

    // supply sense comes from a pin, so it is synchronised first
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            supply_a <= 1'b0;
            supply_b <= 1'b0;
        end else if (enable_in) begin
            supply_a <= input_section_supply_in;
            supply_b <= supply_a;
        end
    end

    // zero wait state slave, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st.rdata;
    assign irq_out = st.irq;
    // diagnostic event mirrors the sticky lost bit
    assign diag_event_out = st.status[`IPM_STAT_LOST_BIT];

    // fast lines feed the counter and frequency units, filtered
    assign count_track_a_out = {level[9], level[6], level[3], level[0]};
    assign count_track_b_out = {level[10], level[7], level[4], level[1]};
    assign count_gate_out = level[11];
    assign count_capture_out = level[15];
    assign freq_meas_out = {level[10], level[7], level[4], level[1]};

    // line indicators follow the filtered level, the supply indicator the synced supply sense
    assign line_led_out = level;
    assign supply_led_out = supply_b;

endmodule

// ===== verif/port_monitor.sv
`timescale 1ns/1ps

// pin-level checker for the sixteen line input port
module port_monitor (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [15:0] line_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic irq_out,
    input wire logic diag_event_out,
    input wire logic [3:0] count_track_a_out,
    input wire logic [3:0] count_track_b_out,
    input wire logic count_gate_out,
    input wire logic count_capture_out,
    input wire logic [3:0] freq_meas_out,
    input wire logic [15:0] line_led_out
);
    logic taken;   // address phase accepted this cycle
    logic wr_any;  // any write address phase
    logic wr_stat; // write aimed at the status word
    logic rd_low;  // read of the low image byte
    logic rd_high; // read of the high image byte
    assign taken = hsel_in && htrans_in[1] && hready_in;
    assign wr_any = taken && hwrite_in;
    assign wr_stat = wr_any && (haddr_in[11:0] == 12'h00C);
    assign rd_low = taken && !hwrite_in && (haddr_in[11:0] == 12'h220);
    assign rd_high = taken && !hwrite_in && (haddr_in[11:0] == 12'h224);

    // one clock domain, so clocking and reset are declared once
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_track_a_route: assert property (
        count_track_a_out == {line_led_out[9], line_led_out[6], line_led_out[3], line_led_out[0]})
        else $error("track a feed does not follow its lines");
    a_track_b_route: assert property (
        count_track_b_out == {line_led_out[10], line_led_out[7], line_led_out[4], line_led_out[1]})
        else $error("track b feed does not follow its lines");
    a_gate_capture: assert property (
        {count_gate_out, count_capture_out} == {line_led_out[11], line_led_out[15]})
        else $error("gate or capture feed wrong");
    a_freq_route: assert property (freq_meas_out == count_track_b_out)
        else $error("frequency feeds wrong");
    // slow line 2 may only go high after its pin has held high a while
    a_led_filtered: assert property (
        $rose(line_led_out[2]) |-> $past(line_in[2], 3) && $past(line_in[2], 12))
        else $error("line 2 rose without a settled pin");
    a_diag_cause: assert property (
        $rose(diag_event_out) |-> $past(line_led_out) != $past(line_led_out, 2))
        else $error("diagnostic raised without an edge");
    // lost flag only drops when software writes a one to it
    a_diag_sticky: assert property (
        $fell(diag_event_out) |-> $past(wr_stat, 2) && $past(hwdata_in[16]))
        else $error("diagnostic dropped without a clear");
    // a mask write reaches irq_out three sampled edges after its address phase
    a_irq_cause: assert property (
        $rose(irq_out) |-> ($past(line_led_out) != $past(line_led_out, 2)) || $past(wr_any, 3))
        else $error("interrupt raised without cause");
    a_image_low: assert property (
        rd_low |=> hrdata_out == {24'h000000, $past(line_led_out[7:0])})
        else $error("low image byte wrong");
    a_image_high: assert property (
        rd_high |=> hrdata_out == {24'h000000, $past(line_led_out[15:8])})
        else $error("high image byte wrong");
endmodule

// ===== verif/field_sensors.sv
`timescale 1ns/1ps

// field sensors: push-pull outputs, optional contact bounce
module field_sensors #(
    parameter int BOUNCE_CYC = 6
) (
    input wire logic clock_in,
    input wire logic [15:0] level_in,  // settled level wanted by the bench
    input wire logic bounce_in,        // high adds chatter on each change
    output logic [15:0] line_out
);
    logic [15:0] held; // last settled level
    logic [15:0] chg;  // lines that are still chattering
    int left;          // chatter cycles remaining
    initial begin
        held = 16'h0000;
        chg = 16'h0000;
        left = 0;
        line_out = 16'h0000;
    end
    // chatter toggles every cycle, shorter than any delay, then settles
    always @(posedge clock_in) begin
        if (level_in != held) begin
            chg <= level_in ^ held;
            held <= level_in;
            left <= bounce_in ? BOUNCE_CYC : 0;
            line_out <= level_in;
        end else if (left > 0) begin
            left <= left - 1;
            line_out <= (left > 1) ? (line_out ^ chg) : held;
        end
    end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps

// self-checking bench for the sixteen line input port
module testbench;
    logic clock_in, resetn_in, supply, hsel, hwrite, bounce;
    logic [15:0] level, line, led;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic hready, hresp, irq, diag, gate, capture, supply_led;
    logic [3:0] track_a, track_b, freq;
    int n_fail, num_checks;

    // short delay counts keep the run brief; 0.1 ms stays 4000 cycles
    sixteen_line_input_port #(.DLY_0P5_CYC(20), .DLY_3_CYC(30), .DLY_15_CYC(40))
        sixteen_line_input_port_inst (
        .clock_in(clock_in), .resetn_in(resetn_in), .enable_in(1'b1),
        .line_in(line), .input_section_supply_in(supply),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
        .irq_out(irq), .diag_event_out(diag), .count_track_a_out(track_a),
        .count_track_b_out(track_b), .count_gate_out(gate),
        .count_capture_out(capture), .freq_meas_out(freq),
        .line_led_out(led), .supply_led_out(supply_led));
    field_sensors field_sensors_inst (.clock_in(clock_in), .level_in(level),
        .bounce_in(bounce), .line_out(line));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task wait_ready;
        @(posedge clock_in);
        while (hready !== 1'b1) @(posedge clock_in);
    endtask

    // one single word transfer; read data taken at the data phase edge
    task bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge clock_in);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'b0, 32'h00000000);
        check(rd, exp, what);
    endtask

    task test_defaults;
        rd_chk(32'h000, 32'h0, "rise enables");
        rd_chk(32'h004, 32'h0, "fall enables");
        rd_chk(32'h008, 32'h0, "delay select");
        rd_chk(32'h010, 32'h0, "mask");
        bus(32'h100, 1'b1, 32'hFFFFFFFF);
        rd_chk(32'h100, 32'h0, "unmapped word");
        $display("test defaults done");
    endtask

    task test_image;
        bus(32'h008, 1'b1, 32'h55);
        level <= 16'hA5C3;
        repeat (30) @(posedge clock_in);
        rd_chk(32'h220, 32'hC3, "image low");
        rd_chk(32'h224, 32'hA5, "image high");
        check({16'h0, led}, 32'hA5C3, "indicators");
        check({28'h0, track_a}, 32'h5, "track a");
        check({28'h0, track_b}, 32'hD, "track b");
        check({30'h0, gate, capture}, 32'h1, "gate capture");
        check({28'h0, freq}, 32'hD, "frequency");
        check({30'h0, supply_led, hresp}, 32'h2, "supply lit, okay");
        $display("test image done");
    endtask

    // groups set to 0.1, 0.5, 3 and 15 ms; slow line 2 falls back to 0.5
    task test_delays;
        level <= 16'h0000;
        repeat (30) @(posedge clock_in);
        bus(32'h008, 1'b1, 32'hE4);
        level <= 16'hFFFF;
        repeat (25) @(posedge clock_in);
        check({16'h0, led}, 32'h00F4, "group 0 and 1");
        repeat (10) @(posedge clock_in);
        check({16'h0, led}, 32'h0FF4, "group 2");
        repeat (10) @(posedge clock_in);
        check({16'h0, led}, 32'hFFF4, "group 3");
        repeat (3945) @(posedge clock_in);
        check({16'h0, led}, 32'hFFF4, "fast lines early");
        repeat (20) @(posedge clock_in);
        check({16'h0, led}, 32'hFFFF, "fast lines");
        $display("test delays done");
    endtask

    task test_edges;
        bus(32'h008, 1'b1, 32'h55);
        bus(32'h000, 1'b1, 32'h5);
        bus(32'h004, 1'b1, 32'h2);
        bus(32'h010, 1'b1, 32'h1FFFF);
        bounce <= 1'b1;
        level <= 16'h0000;
        repeat (40) @(posedge clock_in);
        rd_chk(32'h00C, 32'h2, "falling edge");
        check({31'h0, irq}, 32'h1, "interrupt");
        check({31'h0, diag}, 32'h0, "no diagnostic");
        level <= 16'hFFFF;
        repeat (40) @(posedge clock_in);
        rd_chk(32'h00C, 32'h7, "rising edges");
        level <= 16'h0000;
        repeat (40) @(posedge clock_in);
        rd_chk(32'h00C, 32'h10007, "lost edge");
        check({31'h0, diag}, 32'h1, "diagnostic");
        bus(32'h00C, 1'b1, 32'h1FFFF);
        rd_chk(32'h00C, 32'h0, "cleared");
        check({30'h0, irq, diag}, 32'h0, "irq and diag low");
        $display("test edges done");
    endtask

    // a pulse shorter than the delay is ignored; masking holds irq low
    task test_mask;
        bus(32'h010, 1'b1, 32'h0);
        bounce <= 1'b0;
        level <= 16'h0004;
        repeat (10) @(posedge clock_in);
        level <= 16'h0000;
        repeat (40) @(posedge clock_in);
        rd_chk(32'h00C, 32'h0, "short pulse");
        level <= 16'h0004;
        repeat (40) @(posedge clock_in);
        rd_chk(32'h00C, 32'h4, "masked edge");
        check({31'h0, irq}, 32'h0, "masked irq");
        bus(32'h010, 1'b1, 32'h4);
        repeat (2) @(posedge clock_in);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        bus(32'h00C, 1'b1, 32'h4);
        repeat (2) @(posedge clock_in);
        check({31'h0, irq}, 32'h0, "cleared irq");
        $display("test mask done");
    endtask

    initial begin
        resetn_in = 1'b0;
        level = 16'h0000;
        bounce = 1'b0;
        supply = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        n_fail = 0;
        num_checks = 0;
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        test_defaults();
        test_image();
        test_delays();
        test_edges();
        test_mask();
        finish_test();
    end

    // the whole run needs under 5000 cycles
    initial begin
        repeat (20000) @(posedge clock_in);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule

bind sixteen_line_input_port port_monitor port_monitor_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .line_in(line_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .irq_out(irq_out), .diag_event_out(diag_event_out),
    .count_track_a_out(count_track_a_out), .count_track_b_out(count_track_b_out),
    .count_gate_out(count_gate_out), .count_capture_out(count_capture_out),
    .freq_meas_out(freq_meas_out), .line_led_out(line_led_out));
